// >>> rtl/cdx_cfg.svh
`ifndef CDX_CFG_SVH
`define CDX_CFG_SVH

// Register port offsets
`define CDX_REG_ACC 8'h00
`define CDX_REG_STAT 8'h01
`define CDX_REG_PCL 8'h02
`define CDX_REG_TMR 8'h03
`define CDX_REG_CTRL 8'h04

// Control register fields
`define CDX_CTRL_RUN 0
`define CDX_CTRL_TFCLR 1

// Reset values
`define CDX_RST_BYTE 8'h00
`define CDX_RST_PC 12'h000
`define CDX_RST_RUN 1'b0

// Stack and register bank layout in internal data memory
`define CDX_STACK_BASE 6'h08
`define CDX_BANK1_BASE 6'h18

// Timer prescale: terminal value of the cycle divider
`define CDX_TMR_PRESCALE 5'h1f

`endif

// >>> rtl/cdx_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdx_cfg.svh"

module cdx_core (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic code_valid_i,
  input wire logic [7:0] code_byte_i,
  output logic code_ready_o,
  output logic [11:0] pc_o,
  input wire logic mem_bank_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o,
  output logic bus_oe_n_o,
  output cdx_pkg::cdx_xmem_t xmem_o,
  input wire logic [7:0] p1_i,
  input wire logic [7:0] p2_i,
  output logic [7:0] p1_o,
  output logic [7:0] p2_o,
  output cdx_pkg::cdx_exp_t exp_o,
  input wire logic [3:0] exp_data_i,
  input wire logic t1_i,
  output logic tmr_irq_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  cdx_pkg::cdx_state_t st_q, st_d;
  cdx_pkg::cdx_cnt_t cnt_q, cnt_d;
  cdx_pkg::cdx_exp_t exp_q, exp_d;
  cdx_pkg::cdx_xmem_t xm_q, xm_d;
  logic [7:0] ram_q [0:63];
  logic [7:0] ram_d [0:63];
  logic [7:0] acc_q, acc_d, op_q, op_d, tmr_q, tmr_d;
  logic [7:0] bus_lat_q, bus_lat_d, bus_dat_q, bus_dat_d;
  logic [7:0] p1_q, p1_d, p2_q, p2_d, rdata_q, rdata_d;
  logic [11:0] pc_q, pc_d;
  logic [2:0] stk_q, stk_d;
  logic [4:0] pre_q, pre_d;
  logic cy_q, cy_d, aux_q, aux_d, usr0_q, usr0_d, usr1_q, usr1_d, bs_q, bs_d;
  logic tf_q, tf_d, tien_q, tien_d, run_q, run_d;
  logic bus_out_q, bus_out_d, bus_oe_n_q, bus_oe_n_d, t1_prev_q;
  logic take, take2, need_byte, tick;
  logic [5:0] r_idx, ind_idx, push_idx, pop_idx;
  logic [7:0] r_val, ind_val, b;

  // Working register address in the selected bank
  function automatic logic [5:0] reg_idx(input logic bank,
                                         input logic [2:0] r);
    reg_idx = (bank ? `CDX_BANK1_BASE : 6'h00) + {3'h0, r};
  endfunction : reg_idx

  // Two stack bytes per level
  function automatic logic [5:0] stk_idx(input logic [2:0] lvl);
    stk_idx = `CDX_STACK_BASE + {2'h0, lvl, 1'b0};
  endfunction : stk_idx

  function automatic logic two_cycle(input logic [7:0] o);
    two_cycle = (o[7:1] == 7'h40) || (o[7:1] == 7'h48) ||
                (o[7:4] == 4'h8 && o[3]) || (o[7:4] == 4'h9 && o[3]) ||
                (o[7:3] == 5'h01) || (o[7:3] == 5'h07) ||
                (o == 8'h02) || (o == 8'h83) || (o == 8'h93) ||
                (o[4:0] == 5'h14);
  endfunction : two_cycle

  function automatic logic imm_byte(input logic [7:0] o);
    imm_byte = (o[7:4] == 4'h8 || o[7:4] == 4'h9) && o[3:2] == 2'b10;
    imm_byte = imm_byte || (o[4:0] == 5'h14);
  endfunction : imm_byte

  assign b = code_byte_i;
  assign need_byte = imm_byte(op_q);
  assign code_ready_o = (st_q == cdx_pkg::CDX_ST_FETCH) ? run_q : need_byte;
  assign take = (st_q == cdx_pkg::CDX_ST_FETCH) && run_q && code_valid_i;
  assign take2 = (st_q == cdx_pkg::CDX_ST_EXEC2) &&
                 (!need_byte || code_valid_i);
  assign r_idx = reg_idx(bs_q, b[2:0]);
  assign r_val = ram_q[r_idx];
  assign ind_idx = ram_q[reg_idx(bs_q, {2'h0, b[0]})][5:0];
  assign ind_val = ram_q[ind_idx];
  assign push_idx = stk_idx(stk_q);
  assign pop_idx = stk_idx(stk_q - 3'h1);
  assign tick = (cnt_q == cdx_pkg::CDX_CNT_TIMER) &&
                (pre_q == `CDX_TMR_PRESCALE) ||
                (cnt_q == cdx_pkg::CDX_CNT_EVENT) && t1_prev_q && !t1_i;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    acc_d = acc_q;
    pc_d = pc_q;
    stk_d = stk_q;
    cy_d = cy_q;
    aux_d = aux_q;
    usr0_d = usr0_q;
    usr1_d = usr1_q;
    bs_d = bs_q;
    ram_d = ram_q;
    bus_lat_d = bus_lat_q;
    bus_out_d = bus_out_q;
    p1_d = p1_q;
    p2_d = p2_q;
    exp_d = exp_q;
    exp_d.strobe = 1'b0;
    xm_d = xm_q;
    xm_d.rd = 1'b0;
    xm_d.wr = 1'b0;
    tien_d = tien_q;
    cnt_d = cnt_q;
    tmr_d = tick ? tmr_q + 8'h01 : tmr_q;
    tf_d = tf_q;
    pre_d = (cnt_q == cdx_pkg::CDX_CNT_TIMER) ? pre_q + 5'h01 : 5'h00;
    run_d = run_q;
    rdata_d = `CDX_RST_BYTE;
    if (reg_wr_i && reg_addr_i == `CDX_REG_CTRL) begin
      run_d = reg_wdata_i[`CDX_CTRL_RUN];
      if (reg_wdata_i[`CDX_CTRL_TFCLR]) begin
        tf_d = 1'b0;
      end
    end
    // Overflow set beats a clear in the same cycle
    if (tick && tmr_q == 8'hff) begin
      tf_d = 1'b1;
    end
    if (take) begin
      pc_d = pc_q + 12'h001;
      op_d = b;
      if (two_cycle(b)) begin
        st_d = cdx_pkg::CDX_ST_EXEC2;
      end
      if (b[7:1] == 7'h40) begin
        xm_d.rd = 1'b1;
        xm_d.addr = ram_q[reg_idx(bs_q, {2'h0, b[0]})];
        bus_out_d = 1'b0;
      end else if (b[7:1] == 7'h48) begin
        xm_d.wr = 1'b1;
        xm_d.addr = ram_q[reg_idx(bs_q, {2'h0, b[0]})];
        bus_out_d = 1'b0;
      end else if (b[7:3] == 5'h05) begin
        acc_d = r_val;
        ram_d[r_idx] = acc_q;
      end else if (b[7:1] == 7'h10) begin
        acc_d = ind_val;
        ram_d[ind_idx] = acc_q;
      end else if (b[7:1] == 7'h18) begin
        acc_d = {acc_q[7:4], ind_val[3:0]};
        ram_d[ind_idx] = {ind_val[7:4], acc_q[3:0]};
      end else if (b[7:3] == 5'h19) begin
        ram_d[r_idx] = r_val - 8'h01;
      end else if (b[7:3] == 5'h03) begin
        ram_d[r_idx] = r_val + 8'h01;
      end else if (b[7:1] == 7'h08) begin
        ram_d[ind_idx] = ind_val + 8'h01;
      end else if (b[7:4] == 4'h8 && b[3:2] == 2'b11) begin
        exp_d = '{1'b1, cdx_pkg::CDX_EXP_OR, b[1:0], acc_q[3:0]};
      end else if (b[7:4] == 4'h9 && b[3:2] == 2'b11) begin
        exp_d = '{1'b1, cdx_pkg::CDX_EXP_AND, b[1:0], acc_q[3:0]};
      end else if (b[7:2] == 6'h03) begin
        exp_d = '{1'b1, cdx_pkg::CDX_EXP_READ, b[1:0], 4'h0};
      end else if (b[7:2] == 6'h0f) begin
        exp_d = '{1'b1, cdx_pkg::CDX_EXP_WRITE, b[1:0], acc_q[3:0]};
      end else if (b == 8'h08) begin
        xm_d.rd = 1'b1;
      end else begin
        case (b)
          8'ha7: cy_d = ~cy_q;
          8'h95: usr0_d = ~usr0_q;
          8'hb5: usr1_d = ~usr1_q;
          8'h97: cy_d = 1'b0;
          8'h85: usr0_d = 1'b0;
          8'ha5: usr1_d = 1'b0;
          8'h25: tien_d = 1'b1;
          8'h35: tien_d = 1'b0;
          8'h42: acc_d = tmr_q;
          8'h62: tmr_d = acc_q;
          8'h45: cnt_d = cdx_pkg::CDX_CNT_EVENT;
          8'h55: cnt_d = cdx_pkg::CDX_CNT_TIMER;
          8'h65: cnt_d = cdx_pkg::CDX_CNT_STOP;
          default: ;
        endcase
      end
    end
    if (take2) begin
      st_d = cdx_pkg::CDX_ST_FETCH;
      if (need_byte) begin
        pc_d = pc_q + 12'h001;
      end
      if (op_q[7:1] == 7'h40 || op_q == 8'h08) begin
        acc_d = bus_i;
      end else if (op_q == 8'h98) begin
        bus_lat_d = bus_lat_q & b;
      end else if (op_q == 8'h88) begin
        bus_lat_d = bus_lat_q | b;
      end else if (op_q == 8'h99 || op_q == 8'h9a) begin
        p1_d = op_q[0] ? p1_q & b : p1_q;
        p2_d = op_q[1] ? p2_q & b : p2_q;
      end else if (op_q == 8'h89 || op_q == 8'h8a) begin
        p1_d = op_q[0] ? p1_q | b : p1_q;
        p2_d = op_q[1] ? p2_q | b : p2_q;
      end else if (op_q == 8'h09 || op_q == 8'h0a) begin
        acc_d = op_q[0] ? p1_i : p2_i;
      end else if (op_q[7:2] == 6'h03) begin
        acc_d = {4'h0, exp_data_i};
      end else if (op_q == 8'h02) begin
        bus_lat_d = acc_q;
        bus_out_d = 1'b1;
      end else if (op_q == 8'h39) begin
        p1_d = acc_q;
      end else if (op_q == 8'h3a) begin
        p2_d = acc_q;
      end else if (op_q == 8'h83 || op_q == 8'h93) begin
        stk_d = stk_q - 3'h1;
        pc_d = {ram_q[pop_idx + 6'h01][3:0], ram_q[pop_idx]};
        if (op_q[4]) begin
          {cy_d, aux_d, usr0_d, bs_d} = ram_q[pop_idx + 6'h01][7:4];
        end
      end else if (op_q[4:0] == 5'h14) begin
        ram_d[push_idx] = pc_d[7:0];
        ram_d[push_idx + 6'h01] = {cy_q, aux_q, usr0_q, bs_q, pc_d[11:8]};
        stk_d = stk_q + 3'h1;
        pc_d = {mem_bank_i, op_q[7:5], b};
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `CDX_REG_ACC) begin
        rdata_d = acc_q;
      end else if (reg_addr_i == `CDX_REG_STAT) begin
        rdata_d = {cy_q, aux_q, usr0_q, bs_q, 1'b1, stk_q};
      end else if (reg_addr_i == `CDX_REG_PCL) begin
        rdata_d = pc_q[7:0];
      end else if (reg_addr_i == `CDX_REG_TMR) begin
        rdata_d = tmr_q;
      end else if (reg_addr_i == `CDX_REG_CTRL) begin
        rdata_d = {3'h0, usr1_q, tf_q, tien_q, cnt_q != cdx_pkg::CDX_CNT_STOP,
                   run_q};
      end else begin
        rdata_d = `CDX_RST_BYTE;
      end
    end
    // External write drives the data; otherwise the latch shows when output
    bus_dat_d = xm_d.wr ? acc_q : bus_lat_d;
    bus_oe_n_d = !(xm_d.wr || bus_out_d);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= cdx_pkg::CDX_ST_FETCH;
      op_q <= `CDX_RST_BYTE;
      acc_q <= `CDX_RST_BYTE;
      pc_q <= `CDX_RST_PC;
      stk_q <= 3'h0;
      {cy_q, aux_q, usr0_q, usr1_q, bs_q} <= 5'h00;
      for (int i = 0; i < 64; i++) begin
        ram_q[i] <= `CDX_RST_BYTE;
      end
      bus_lat_q <= `CDX_RST_BYTE;
      bus_dat_q <= `CDX_RST_BYTE;
      bus_out_q <= 1'b0;
      bus_oe_n_q <= 1'b1;
      p1_q <= 8'hff;
      p2_q <= 8'hff;
      exp_q <= '0;
      xm_q <= '0;
      tien_q <= 1'b0;
      cnt_q <= cdx_pkg::CDX_CNT_STOP;
      tmr_q <= `CDX_RST_BYTE;
      tf_q <= 1'b0;
      pre_q <= 5'h00;
      t1_prev_q <= 1'b0;
      run_q <= `CDX_RST_RUN;
      rdata_q <= `CDX_RST_BYTE;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      acc_q <= acc_d;
      pc_q <= pc_d;
      stk_q <= stk_d;
      {cy_q, aux_q, usr0_q, usr1_q, bs_q} <=
        {cy_d, aux_d, usr0_d, usr1_d, bs_d};
      ram_q <= ram_d;
      bus_lat_q <= bus_lat_d;
      bus_dat_q <= bus_dat_d;
      bus_out_q <= bus_out_d;
      bus_oe_n_q <= bus_oe_n_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      exp_q <= exp_d;
      xm_q <= xm_d;
      tien_q <= tien_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      tf_q <= tf_d;
      pre_q <= pre_d;
      t1_prev_q <= t1_i;
      run_q <= run_d;
      rdata_q <= rdata_d;
    end
  end

  assign pc_o = pc_q;
  assign bus_o = bus_dat_q;
  assign bus_oe_n_o = bus_oe_n_q;
  assign xmem_o = xm_q;
  assign p1_o = p1_q;
  assign p2_o = p2_q;
  assign exp_o = exp_q;
  assign tmr_irq_o = tf_q && tien_q;
  assign reg_rdata_o = rdata_q;

  property flag_keep_p;
    @(posedge clk_i) disable iff (sys_rst_i)
      take && b == 8'ha7 |=> cy_q != $past(cy_q) && usr0_q == $past(usr0_q);
  endproperty

  swap_reg_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b[7:3] == 5'h05 |=> acc_q == $past(r_val))
    else $error("register swap lost the value");
  invert_carry_a: assert property (flag_keep_p)
    else $error("carry invert wrong");
  clear_user0_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b == 8'h85 |=> !usr0_q && cy_q == $past(cy_q))
    else $error("flag zero clear wrong");
  xmove_release_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b[7:1] == 7'h40 |=> !bus_out_q && xm_q.rd)
    else $error("external move kept bus driven");
  bus_drive_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b == 8'h02 |-> ##2 !bus_oe_n_o && bus_o == $past(acc_q, 2))
    else $error("bus write not driven");
  exp_read_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b[7:2] == 6'h03 |-> ##2 acc_q[7:4] == 4'h0)
    else $error("expander read upper bits not zero");
  two_cycle_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take && b == 8'h39 |=> st_q == cdx_pkg::CDX_ST_EXEC2 ##1
    st_q == cdx_pkg::CDX_ST_FETCH && p1_o == $past(acc_q, 2))
    else $error("port write timing wrong");
  call_stack_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take2 && op_q[4:0] == 5'h14 |=> stk_q == $past(stk_q) + 3'h1 &&
    pc_o[10:0] == {$past(op_q[7:5]), $past(b)})
    else $error("call did not load address");
  stack_pop_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    take2 && op_q == 8'h83 |=> stk_q == $past(stk_q) - 3'h1)
    else $error("return did not pop");

  call_c: cover property (@(posedge clk_i) take && b[4:0] == 5'h14);
  exit_status_c: cover property (@(posedge clk_i) take && b == 8'h93);
  xread_c: cover property (@(posedge clk_i) take && b[7:1] == 7'h40);
  ovf_c: cover property (@(posedge clk_i) tick && tmr_q == 8'hff);

endmodule : cdx_core

`default_nettype wire

// >>> rtl/cdx_pkg.sv
package cdx_pkg;

  typedef enum logic [1:0] {
    CDX_ST_FETCH = 2'b01,
    CDX_ST_EXEC2 = 2'b10
  } cdx_state_t;

  typedef enum logic [1:0] {
    CDX_CNT_STOP = 2'h0,
    CDX_CNT_TIMER = 2'h1,
    CDX_CNT_EVENT = 2'h2
  } cdx_cnt_t;

  typedef enum logic [1:0] {
    CDX_EXP_READ = 2'h0,
    CDX_EXP_WRITE = 2'h1,
    CDX_EXP_OR = 2'h2,
    CDX_EXP_AND = 2'h3
  } cdx_exp_cmd_t;

  // Port expander command group
  typedef struct packed {
    logic strobe;
    cdx_exp_cmd_t cmd;
    logic [1:0] port;
    logic [3:0] data;
  } cdx_exp_t;

  // External data memory access group
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
  } cdx_xmem_t;

endpackage : cdx_pkg

// >>> testbench/cdx_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdx_far_model (
  input wire logic clk_i,
  input wire cdx_pkg::cdx_xmem_t xmem_i,
  input wire cdx_pkg::cdx_exp_t exp_i,
  input wire logic [7:0] bus_o_i,
  input wire logic bus_oe_n_i,
  input wire logic [7:0] p1_o_i,
  input wire logic [7:0] p2_o_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] bus_i_o,
  output logic [7:0] p1_i_o,
  output logic [7:0] p2_i_o,
  output logic [3:0] exp_data_o
);
  logic [7:0] xram [256];
  logic [3:0] xport [4];
  logic [3:0] cur;
  assign cur = xport[exp_i.port];
  // Memory answers only during its read; otherwise whoever drives the bus
  assign bus_i_o = xmem_i.rd ? xram[xmem_i.addr] :
                   (bus_oe_n_i ? ext_i : bus_o_i);
  // Weak pull-up lines on port 1: the outside world may only pull low; port 2 reads back its output
  assign p1_i_o = p1_o_i & ext_i;
  assign p2_i_o = p2_o_i;
  // Nibble lines float outside a strobe, so show the inverse
  assign exp_data_o = exp_i.strobe ? cur : ~cur;
  always @(posedge clk_i) begin
    if (xmem_i.wr) begin
      xram[xmem_i.addr] <= bus_o_i;
    end
    if (exp_i.strobe) begin
      case (exp_i.cmd)
        cdx_pkg::CDX_EXP_WRITE: xport[exp_i.port] <= exp_i.data;
        cdx_pkg::CDX_EXP_OR: xport[exp_i.port] <= cur | exp_i.data;
        cdx_pkg::CDX_EXP_AND: xport[exp_i.port] <= cur & exp_i.data;
        default: ;
      endcase
    end
  end
endmodule : cdx_far_model
`default_nettype wire

// >>> testbench/test_cpu_data_io_timer_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_data_io_timer_decode;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic code_valid_i = 1'b0;
  logic [7:0] code_byte_i = 8'h00;
  logic mem_bank_i = 1'b0;
  logic t1_i = 1'b0;
  logic [7:0] ext = 8'hff;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic code_ready_o, bus_oe_n_o, tmr_irq_o;
  logic [11:0] pc_o;
  logic [7:0] bus_i, bus_o, p1_i, p2_i, p1_o, p2_o, reg_rdata_o;
  logic [3:0] exp_data_i;
  cdx_pkg::cdx_xmem_t xmem_o;
  cdx_pkg::cdx_exp_t exp_o;
  int n_errors = 0;
  int n_tests = 0;
  always #50 clk_i = ~clk_i;
  cdx_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .code_valid_i(code_valid_i), .code_byte_i(code_byte_i),
    .code_ready_o(code_ready_o), .pc_o(pc_o), .mem_bank_i(mem_bank_i),
    .bus_i(bus_i), .bus_o(bus_o), .bus_oe_n_o(bus_oe_n_o), .xmem_o(xmem_o),
    .p1_i(p1_i), .p2_i(p2_i), .p1_o(p1_o), .p2_o(p2_o), .exp_o(exp_o),
    .exp_data_i(exp_data_i), .t1_i(t1_i), .tmr_irq_o(tmr_irq_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  cdx_far_model far (.clk_i(clk_i), .xmem_i(xmem_o), .exp_i(exp_o),
    .bus_o_i(bus_o), .bus_oe_n_i(bus_oe_n_o), .p1_o_i(p1_o), .p2_o_i(p2_o),
    .ext_i(ext), .bus_i_o(bus_i), .p1_i_o(p1_i), .p2_i_o(p2_i),
    .exp_data_o(exp_data_i));

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [11:0] g, input logic [11:0] e, string w);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask : chk

  // Holds valid between bytes so it is never dropped and raised in one step
  task automatic send(input logic [7:0] b);
    int k = 0;
    code_valid_i <= 1'b1;
    code_byte_i <= b;
    do begin
      @(posedge clk_i);
      k++;
    end while (code_ready_o !== 1'b1 && k < 20);
    if (k >= 20) chk(1'b0, 1'b1, "take");
  endtask : send

  task automatic op2(input logic [7:0] a, input logic [7:0] b, bit two);
    send(a);
    if (two) send(b);
    code_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : op2

  task automatic op(input logic [7:0] a);
    op2(a, 8'h00, 1'b0);
  endtask : op

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] e, string w);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e, w);
    @(posedge clk_i);
  endtask : rreg

  task automatic lda(input logic [7:0] v);
    ext <= v;
    op(8'h09);
  endtask : lda

  task automatic t_reset;
    chk(code_ready_o, 1'b0, "ready");
    chk(p1_o, 8'hff, "p1");
    chk(bus_oe_n_o, 1'b1, "oe");
    rreg(8'h01, 8'h08, "status");
    rreg(8'h07, 8'h00, "unmapped");
    wreg(8'h04, 8'h01);
    rreg(8'h04, 8'h01, "run");
    $display("reset test done");
  endtask : t_reset

  task automatic t_ports;
    lda(8'ha5);
    rreg(8'h00, 8'ha5, "in p1");
    op(8'h3a);
    chk(p2_o, 8'ha5, "out p2");
    op(8'h39);
    chk(p1_o, 8'ha5, "out p1");
    op2(8'h9a, 8'h0f, 1'b1);
    chk(p2_o, 8'h05, "and p2");
    op2(8'h8a, 8'h30, 1'b1);
    chk(p2_o, 8'h35, "or p2");
    op(8'h0a);
    rreg(8'h00, 8'h35, "in p2");
    op2(8'h99, 8'hf0, 1'b1);
    chk(p1_o, 8'ha0, "and p1");
    op2(8'h89, 8'h5f, 1'b1);
    chk(p1_o, 8'hff, "or p1");
    // The strobe pulses the memory read, so memory at the held address answers
    far.xram[8'h00] = 8'hc6;
    op(8'h08);
    rreg(8'h00, 8'hc6, "strobed");
    $display("port test done");
  endtask : t_ports

  task automatic t_regs;
    lda(8'ha5);
    op(8'h2b);
    rreg(8'h00, 8'h00, "swap r3");
    op(8'h1b);
    op(8'hcb);
    op(8'hcb);
    op(8'h2b);
    rreg(8'h00, 8'ha4, "inc dec");
    rreg(8'h01, 8'h08, "flags");
    lda(8'h20);
    op(8'h29);
    lda(8'hb7);
    op(8'h21);
    op(8'h11);
    lda(8'h4c);
    op(8'h31);
    rreg(8'h00, 8'h48, "nibble");
    op(8'h21);
    rreg(8'h00, 8'hbc, "swap ind");
    $display("register test done");
  endtask : t_regs

  task automatic t_flags;
    logic [7:0] c [6] = '{8'ha7, 8'h95, 8'h97, 8'hb5, 8'h85, 8'ha5};
    logic [7:0] p [6] = '{8'h88, 8'ha8, 8'h28, 8'h28, 8'h08, 8'h08};
    logic [7:0] f [6] = '{8'h01, 8'h01, 8'h01, 8'h11, 8'h11, 8'h01};
    for (int i = 0; i < 6; i++) begin
      op(c[i]);
      rreg(8'h01, p[i], "status");
      rreg(8'h04, f[i], "ctrl");
    end
    $display("flag test done");
  endtask : t_flags

  task automatic t_bus;
    lda(8'h3c);
    op(8'h28);
    lda(8'h5a);
    op(8'h02);
    chk(bus_o, 8'h5a, "bus out");
    op2(8'h98, 8'h0f, 1'b1);
    chk(bus_o, 8'h0a, "and bus");
    op2(8'h88, 8'h30, 1'b1);
    chk(bus_o, 8'h3a, "or bus");
    chk(bus_oe_n_o, 1'b0, "oe held");
    op(8'h90);
    chk(far.xram[8'h3c], 8'h5a, "wr r0");
    chk(bus_oe_n_o, 1'b1, "oe off");
    lda(8'h77);
    op(8'h91);
    chk(far.xram[8'h20], 8'h77, "wr r1");
    lda(8'h00);
    op(8'h80);
    rreg(8'h00, 8'h5a, "rd r0");
    op(8'h81);
    rreg(8'h00, 8'h77, "rd r1");
    op(8'h02);
    chk(bus_oe_n_o, 1'b0, "oe again");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk(bus_oe_n_o, 1'b1, "oe reset");
    wreg(8'h04, 8'h01);
    $display("bus test done");
  endtask : t_bus

  task automatic t_exp;
    lda(8'hf9);
    op(8'h3d);
    chk(far.xport[1], 4'h9, "exp wr");
    lda(8'h06);
    op(8'h8d);
    chk(far.xport[1], 4'hf, "exp or");
    lda(8'h03);
    op(8'h9d);
    chk(far.xport[1], 4'h3, "exp and");
    lda(8'hf0);
    op(8'h0d);
    rreg(8'h00, 8'h03, "exp rd");
    $display("expander test done");
  endtask : t_exp

  task automatic t_timer;
    int k = 0;
    lda(8'hfe);
    op(8'h62);
    rreg(8'h03, 8'hfe, "tmr load");
    op(8'h25);
    op(8'h55);
    rreg(8'h04, 8'h07, "tmr run");
    while (tmr_irq_o !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    chk(tmr_irq_o, 1'b1, "irq");
    op(8'h35);
    chk(tmr_irq_o, 1'b0, "irq off");
    op(8'h65);
    wreg(8'h04, 8'h03);
    rreg(8'h04, 8'h01, "stopped");
    lda(8'h00);
    op(8'h62);
    op(8'h45);
    rreg(8'h04, 8'h03, "evt run");
    repeat (3) begin
      t1_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t1_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    op(8'h65);
    op(8'h42);
    rreg(8'h00, 8'h03, "events");
    $display("timer test done");
  endtask : t_timer

  task automatic t_call;
    logic [11:0] p0;
    mem_bank_i <= 1'b1;
    op(8'ha7);
    p0 = pc_o;
    op2(8'h54, 8'h77, 1'b1);
    chk(pc_o, 12'ha77, "call pc");
    rreg(8'h01, 8'h89, "call stack");
    op(8'h97);
    op(8'h93);
    chk(pc_o, p0 + 12'h002, "pop pc status");
    rreg(8'h01, 8'h88, "pop status");
    op(8'h97);
    p0 = pc_o;
    op2(8'h54, 8'h77, 1'b1);
    op(8'ha7);
    op(8'h83);
    chk(pc_o, p0 + 12'h002, "pop pc");
    rreg(8'h01, 8'h88, "pop flags kept");
    $display("call test done");
  endtask : t_call

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_ports;
    t_regs;
    t_flags;
    t_bus;
    t_exp;
    t_timer;
    t_call;
    results;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("MISMATCH at %0t: watchdog", $time);
    results;
  end
endmodule : test_cpu_data_io_timer_decode
`default_nettype wire
